// File: can_mode_map.svh
// Register offsets, field positions and reset values of the mode-control block.
// Assumes inclusion by the mode-control design file and the testbench by bare name.
`ifndef CAN_MODE_MAP_SVH
`define CAN_MODE_MAP_SVH

// Each register takes one aligned word: byte address is four times the index
`define CTRL_INDEX 10'h000
`define TEST_INDEX 10'h00A
`define FD_CTRL_INDEX 10'h026
`define SET_ONE_REQ_INDEX 10'h010
`define SET_TWO_REQ_INDEX 10'h040
`define STATUS_INDEX 10'h080

`define CTRL_OFFSET {`CTRL_INDEX, 2'h0}
`define TEST_OFFSET {`TEST_INDEX, 2'h0}
`define FD_CTRL_OFFSET {`FD_CTRL_INDEX, 2'h0}
`define SET_ONE_REQ_OFFSET {`SET_ONE_REQ_INDEX, 2'h0}
`define SET_TWO_REQ_OFFSET {`SET_TWO_REQ_INDEX, 2'h0}
`define STATUS_OFFSET {`STATUS_INDEX, 2'h0}

`define CTRL_INIT_BIT 0
`define CTRL_RETRY_OFF_BIT 5
`define CTRL_CFG_CHANGE_BIT 6
`define CTRL_TEST_BIT 7
`define TEST_BASIC_BIT 2
`define TEST_SILENT_BIT 3
`define TEST_LOOP_BIT 4
`define TEST_TX_LO_BIT 5
`define TEST_TX_HI_BIT 6
`define TEST_RX_BIT 7
`define FD_FAST_BIT 0
`define FD_RESTRICT_BIT 1
`define REQ_BUSY_BIT 15

`define CTRL_RESET 8'h01

`endif

// File: can_mode_pkg.sv
// Types shared by the mode-control block.
// Assumes the constants header is available by bare name.
package can_mode_pkg;
    typedef enum logic [1:0] {
        TX_SERIAL,
        TX_SAMPLE,
        TX_DOMINANT,
        TX_RECESSIVE
    } tx_select_t;

    typedef enum logic [1:0] {
        XMIT_IDLE,
        XMIT_PENDING,
        XMIT_ACTIVE
    } xmit_state_t;
endpackage

// File: can_pin_path.sv
// CAN pin routing: output select, loopback and listen-only paths.
// Assumes core_tx and sample strobe from the protocol core on ref_clk.
`timescale 1ns/10ps
`default_nettype none

module can_pin_path (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic test_on,
    input wire logic loopback_enable,
    input wire logic listen_only,
    input wire logic restricted,
    input wire logic [1:0] pin_sel,
    input wire logic core_tx,
    input wire logic sample_point,
    input wire logic bus_rx,
    output logic bus_tx,
    output logic core_rx
);
    typedef struct packed {
        logic tx;
        logic rx;
    } pin_state_t;

    pin_state_t state;
    pin_state_t next_state;
    logic lb;
    logic lo;
    logic dominant_out;

    always_comb begin
        lb = test_on & loopback_enable;
        lo = test_on & listen_only;
        // Restricted operation keeps the serial output recessive; the pin_sel sample and dominant settings can still drive dominant
        dominant_out = core_tx | lo | restricted;
        next_state = state;
        if (!test_on) begin
            next_state.tx = core_tx | restricted;
        end else begin
            case (can_mode_pkg::tx_select_t'(pin_sel))
                can_mode_pkg::TX_SERIAL: next_state.tx = dominant_out;
                can_mode_pkg::TX_SAMPLE: next_state.tx = sample_point;
                can_mode_pkg::TX_DOMINANT: next_state.tx = 1'b0;
                can_mode_pkg::TX_RECESSIVE: next_state.tx = 1'b1;
                default: next_state.tx = 1'b1;
            endcase
        end
        if (lb) begin
            next_state.rx = core_tx;
        end else if (lo || restricted) begin
            // Own dominant bits are seen internally only
            next_state.rx = bus_rx & core_tx;
        end else begin
            next_state.rx = bus_rx;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '{tx: 1'b1, rx: 1'b1};
        end else begin
            state <= next_state;
        end
    end

    assign bus_tx = state.tx;
    assign core_rx = state.rx;

    AST_SILENT_RECESSIVE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (test_on && listen_only && pin_sel == 2'h0) |=> bus_tx)
        else $error("listen-only drove dominant");
    AST_LOOPBACK_RX: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (test_on && loopback_enable) |=> core_rx == $past(core_tx))
        else $error("loopback feed wrong");
endmodule

`default_nettype wire

// File: can_mode_control.sv
// Mode control of a CAN controller: protected bits, test register,
// single-shot retransmission and direct-buffer transmit/receive handshake.
// Assumes an APB master on ref_clk and a protocol core that reports events.
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "can_mode_map.svh"

module can_mode_control (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic can_rx,
    output logic can_tx,
    input wire logic core_tx,
    input wire logic sample_point,
    output logic core_rx,
    input wire logic bus_idle,
    input wire logic tx_started,
    input wire logic tx_success,
    input wire logic tx_failed,
    input wire logic rx_frame_done,
    input wire logic error_logging,
    output logic tx_allowed,
    output logic tx_load,
    output logic retransmit_enable,
    output logic counters_frozen,
    output logic ack_error_ignore,
    output logic loopback_store,
    output logic fast_data_operation_enable,
    output logic filter_bypass,
    output logic set_two_capture,
    output logic ready_out
);
    typedef struct packed {
        logic init;
        logic config_change_enable;
        logic retransmission_disable;
        logic test_on;
        logic fast_data_operation_enable;
        logic restricted_mode_enable;
        logic [1:0] pin_sel;
        logic loopback_enable;
        logic listen_only;
        logic direct_buffer;
        logic transmit_request_flag;
        logic new_data_flag;
        logic set_one_busy;
        logic aborted;
        logic set_two_capture;
        logic tx_load;
        logic [31:0] rdata;
        logic ready;
        logic tx_allowed;
        logic retransmit_enable;
        logic counters_frozen;
        logic ack_ignore;
        logic lb_store;
        logic filter_bypass;
        logic ready_out;
        can_mode_pkg::xmit_state_t xmit;
    } ctrl_state_t;

    ctrl_state_t state;
    ctrl_state_t next_state;
    logic wr;
    logic rd_setup;
    logic protect_open;
    logic lb_on;
    logic lo_on;
    logic basic_on;

    ////////////////////////////////////////////////////////////////////////////
    // Register bus and mode state

    always_comb begin
        next_state = state;
        wr = psel & penable & pwrite & ~state.ready;
        rd_setup = psel & ~penable;
        protect_open = state.config_change_enable & state.init;
        lb_on = state.test_on & state.loopback_enable;
        lo_on = state.test_on & state.listen_only;
        basic_on = state.test_on & state.direct_buffer;
        next_state.ready = psel & penable & ~state.ready;
        next_state.set_two_capture = 1'b0;
        next_state.tx_load = 1'b0;

        if (wr) begin
            case (paddr)
                `CTRL_OFFSET: begin
                    next_state.init = pwdata[`CTRL_INIT_BIT];
                    next_state.retransmission_disable = pwdata[`CTRL_RETRY_OFF_BIT];
                    next_state.config_change_enable = pwdata[`CTRL_CFG_CHANGE_BIT];
                    next_state.test_on = pwdata[`CTRL_TEST_BIT];
                end
                `FD_CTRL_OFFSET: begin
                    if (protect_open) begin
                        next_state.fast_data_operation_enable = pwdata[`FD_FAST_BIT];
                        next_state.restricted_mode_enable = pwdata[`FD_RESTRICT_BIT];
                    end
                end
                `TEST_OFFSET: begin
                    if (state.test_on) begin
                        next_state.direct_buffer = pwdata[`TEST_BASIC_BIT];
                        next_state.listen_only = pwdata[`TEST_SILENT_BIT];
                        next_state.loopback_enable = pwdata[`TEST_LOOP_BIT];
                        next_state.pin_sel = {pwdata[`TEST_TX_HI_BIT], pwdata[`TEST_TX_LO_BIT]};
                    end
                end
                `SET_ONE_REQ_OFFSET: begin
                    // Busy write requests; clearing while busy aborts
                    if (pwdata[`REQ_BUSY_BIT]) begin
                        next_state.set_one_busy = 1'b1;
                        next_state.transmit_request_flag = 1'b1;
                        next_state.new_data_flag = 1'b1;
                        next_state.aborted = 1'b0;
                    end else if (state.set_one_busy) begin
                        next_state.set_one_busy = 1'b0;
                        next_state.transmit_request_flag = 1'b0;
                        next_state.aborted = 1'b1;
                    end
                end
                `SET_TWO_REQ_OFFSET: begin
                    if (basic_on && pwdata[`REQ_BUSY_BIT]) begin
                        next_state.set_two_capture = 1'b1;
                    end
                end
                default: begin end
            endcase
        end

        ////////////////////////////////////////////////////////////////////////
        // Transmission sequencing
        case (state.xmit)
            can_mode_pkg::XMIT_IDLE: begin
                if (state.transmit_request_flag && !state.init && bus_idle) begin
                    next_state.xmit = can_mode_pkg::XMIT_ACTIVE;
                    next_state.tx_load = basic_on;
                end
            end
            can_mode_pkg::XMIT_ACTIVE: begin
                if (tx_started && state.retransmission_disable) begin
                    next_state.transmit_request_flag = 1'b0;
                end
                if (tx_success) begin
                    next_state.transmit_request_flag = 1'b0;
                    next_state.new_data_flag = 1'b0;
                    next_state.set_one_busy = 1'b0;
                    next_state.xmit = can_mode_pkg::XMIT_IDLE;
                end else if (tx_failed) begin
                    // New data stays set; host re-requests in single shot
                    if (state.retransmission_disable || state.aborted) begin
                        next_state.transmit_request_flag = 1'b0;
                        next_state.set_one_busy = 1'b0;
                    end
                    next_state.xmit = can_mode_pkg::XMIT_IDLE;
                end
            end
            default: next_state.xmit = can_mode_pkg::XMIT_IDLE;
        endcase
        // A late host set during completion wins over the clear
        if (wr && paddr == `SET_ONE_REQ_OFFSET && pwdata[`REQ_BUSY_BIT]) begin
            next_state.transmit_request_flag = 1'b1;
            next_state.new_data_flag = 1'b1;
            next_state.aborted = 1'b0;
            next_state.set_one_busy = 1'b1;
        end

        if (basic_on && rx_frame_done) begin
            next_state.set_two_capture = 1'b1;
        end

        next_state.tx_allowed = state.transmit_request_flag & ~state.init
            & ~state.restricted_mode_enable & ~lo_on;
        next_state.retransmit_enable = ~state.retransmission_disable
            & ~state.aborted;
        next_state.counters_frozen = state.restricted_mode_enable & error_logging;
        next_state.ack_ignore = lb_on;
        next_state.lb_store = lb_on;
        next_state.filter_bypass = basic_on;
        next_state.ready_out = ~basic_on & state.new_data_flag;

        next_state.rdata = 32'h0000_0000;
        if (rd_setup) begin
            case (paddr)
                `CTRL_OFFSET: begin
                    next_state.rdata[`CTRL_INIT_BIT] = state.init;
                    next_state.rdata[`CTRL_RETRY_OFF_BIT] = state.retransmission_disable;
                    next_state.rdata[`CTRL_CFG_CHANGE_BIT] = state.config_change_enable;
                    next_state.rdata[`CTRL_TEST_BIT] = state.test_on;
                end
                `FD_CTRL_OFFSET: begin
                    next_state.rdata[`FD_FAST_BIT] = state.fast_data_operation_enable;
                    next_state.rdata[`FD_RESTRICT_BIT] = state.restricted_mode_enable;
                end
                `TEST_OFFSET: begin
                    next_state.rdata[`TEST_BASIC_BIT] = state.direct_buffer;
                    next_state.rdata[`TEST_SILENT_BIT] = state.listen_only;
                    next_state.rdata[`TEST_LOOP_BIT] = state.loopback_enable;
                    next_state.rdata[`TEST_TX_LO_BIT] = state.pin_sel[0];
                    next_state.rdata[`TEST_TX_HI_BIT] = state.pin_sel[1];
                    next_state.rdata[`TEST_RX_BIT] = can_rx;
                end
                `SET_ONE_REQ_OFFSET: next_state.rdata[`REQ_BUSY_BIT] = state.set_one_busy;
                `STATUS_OFFSET: begin
                    next_state.rdata[0] = state.transmit_request_flag;
                    next_state.rdata[1] = state.new_data_flag;
                end
                default: begin end
            endcase
        end else if (psel && penable) begin
            next_state.rdata = state.rdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
            state.init <= 1'b1;
            state.retransmit_enable <= 1'b1;
            state.xmit <= can_mode_pkg::XMIT_IDLE;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin path and outputs

    can_pin_path pins (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .test_on(state.test_on),
        .loopback_enable(state.loopback_enable),
        .listen_only(state.listen_only),
        .restricted(state.restricted_mode_enable),
        .pin_sel(state.pin_sel),
        .core_tx(core_tx | state.init),
        .sample_point(sample_point),
        .bus_rx(can_rx),
        .bus_tx(can_tx),
        .core_rx(core_rx)
    );

    assign prdata = state.rdata;
    assign pready = state.ready;
    assign pslverr = 1'b0;
    assign tx_allowed = state.tx_allowed;
    assign tx_load = state.tx_load;
    assign retransmit_enable = state.retransmit_enable;
    assign counters_frozen = state.counters_frozen;
    assign ack_error_ignore = state.ack_ignore;
    assign loopback_store = state.lb_store;
    assign fast_data_operation_enable = state.fast_data_operation_enable;
    assign filter_bypass = state.filter_bypass;
    assign set_two_capture = state.set_two_capture;
    assign ready_out = state.ready_out;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    AST_FAST_PROTECT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !(state.config_change_enable && state.init)
        |=> $stable(state.fast_data_operation_enable))
        else $error("fd enable changed while protected");
    AST_RESTRICT_PROTECT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !protect_open |=> $stable(state.restricted_mode_enable))
        else $error("restricted enable changed while protected");
    AST_TEST_LOCK: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !state.test_on |=> $stable(state.pin_sel) && $stable(state.loopback_enable))
        else $error("test bits changed outside test mode");
    AST_NO_TX_RESTRICTED: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state.restricted_mode_enable |=> !tx_allowed)
        else $error("transmit allowed in restricted mode");
    AST_FREEZE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state.restricted_mode_enable && error_logging) |=> counters_frozen)
        else $error("counters not frozen");
    AST_SINGLE_SHOT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state.xmit == can_mode_pkg::XMIT_ACTIVE && tx_started && !tx_success
         && state.retransmission_disable && !wr) |=> !state.transmit_request_flag
         && state.new_data_flag)
        else $error("single shot flags wrong");
    AST_FAIL_KEEP: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state.xmit == can_mode_pkg::XMIT_ACTIVE && tx_failed && !tx_success
         && state.new_data_flag && !wr) |=> state.new_data_flag)
        else $error("new data lost on failure");
    AST_BASIC_CAPTURE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state.test_on && state.direct_buffer && rx_frame_done) |=> set_two_capture)
        else $error("receive frame not captured");
    AST_RX_MONITOR: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (psel && !penable && paddr == `TEST_OFFSET) |=> prdata[`TEST_RX_BIT] == $past(can_rx))
        else $error("rx monitor wrong");
endmodule

`default_nettype wire

// File: can_bus_model.sv
// Behavioural CAN protocol core and bus seen from the mode-control block.
// Assumes its tasks are called just after a rising edge of ref_clk.
`timescale 1ns/10ps
`default_nettype none

module can_bus_model (
    input wire logic ref_clk,
    input wire logic can_tx,
    output logic can_rx,
    output logic core_tx,
    output logic sample_point,
    output logic bus_idle,
    output logic tx_started,
    output logic tx_success,
    output logic tx_failed,
    output logic rx_frame_done,
    output logic error_logging
);
    // Levels as {core_tx, sample_point, error_logging, other node}
    logic [3:0] lvl = 4'h9;
    // Core event shown this cycle: 0 idle, 1 start, 2 success, 3 fail, 4 frame
    int event_code = -1;

    // Wired-AND bus: any dominant node wins, the idle bus floats recessive
    assign can_rx = can_tx & lvl[0];
    assign core_tx = lvl[3];
    assign sample_point = lvl[2];
    assign error_logging = lvl[1];
    assign bus_idle = (event_code == 0);
    assign tx_started = (event_code == 1);
    assign tx_success = (event_code == 2);
    assign tx_failed = (event_code == 3);
    assign rx_frame_done = (event_code == 4);

    task automatic levels(input logic ctx, input logic oth, input logic sp, input logic err);
        lvl <= {ctx, sp, err, oth};
    endtask

    // Core events last one cycle, then a quiet cycle lets the flags settle
    task automatic pulse(input int code);
        event_code <= code;
        @(posedge ref_clk);
        event_code <= -1;
        @(posedge ref_clk);
    endtask
endmodule

`default_nettype wire

// File: testbench.sv
// Self-checking bench of the mode-control block over APB.
// Assumes the behavioural bus model stands in for the core and the CAN bus.
`timescale 1ns/10ps
`default_nettype none
`include "can_mode_map.svh"

`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end

module testbench;
    typedef struct packed {
        logic [7:0] tval;
        logic ctx;
        logic oth;
        logic sp;
        logic exp_tx;
        logic exp_rx;
    } row_t;

    logic ref_clk, rst_n, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, can_rx, can_tx, core_tx, sample_point, core_rx, bus_idle;
    logic tx_started, tx_success, tx_failed, rx_frame_done, error_logging;
    logic tx_allowed, tx_load, retransmit_enable, counters_frozen, ack_error_ignore;
    logic loopback_store, fast_data_operation_enable, filter_bypass, set_two_capture, ready_out;
    int n_fail = 0;
    int n_checks = 0;
    int n_load = 0;
    int n_cap = 0;
    row_t rows [12] = '{
        '{8'h00, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0}, '{8'h00, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0},
        '{8'h08, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0}, '{8'h08, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0},
        '{8'h10, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0}, '{8'h10, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1},
        '{8'h18, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0}, '{8'h18, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1},
        '{8'h20, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1}, '{8'h20, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0},
        '{8'h40, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0}, '{8'h60, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1}
    };

    can_mode_control u_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(),
        .can_rx(can_rx), .can_tx(can_tx), .core_tx(core_tx), .sample_point(sample_point),
        .core_rx(core_rx), .bus_idle(bus_idle), .tx_started(tx_started),
        .tx_success(tx_success), .tx_failed(tx_failed), .rx_frame_done(rx_frame_done),
        .error_logging(error_logging), .tx_allowed(tx_allowed), .tx_load(tx_load),
        .retransmit_enable(retransmit_enable), .counters_frozen(counters_frozen),
        .ack_error_ignore(ack_error_ignore), .loopback_store(loopback_store),
        .fast_data_operation_enable(fast_data_operation_enable),
        .filter_bypass(filter_bypass), .set_two_capture(set_two_capture), .ready_out(ready_out)
    );

    can_bus_model u_bus (
        .ref_clk(ref_clk), .can_tx(can_tx), .can_rx(can_rx), .core_tx(core_tx),
        .sample_point(sample_point), .bus_idle(bus_idle), .tx_started(tx_started),
        .tx_success(tx_success), .tx_failed(tx_failed), .rx_frame_done(rx_frame_done),
        .error_logging(error_logging)
    );

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'h0;
        forever #25 ref_clk = ~ref_clk;
    end

    // One-cycle pulses are counted here so no check can miss them
    always @(posedge ref_clk) begin
        if (tx_load === 1'h1) n_load++;
        if (set_two_capture === 1'h1) n_cap++;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'h1;
        // Only the watchdog ends a wait for the slave
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'h1);
        q = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'h1, a, d, q);
    endtask

    task automatic check_reg(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
                             input string nm);
        logic [31:0] q;
        apb(1'h0, a, 32'h0, q);
        `CHK(nm, e, q & m)
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        #2000000;
        n_fail++;
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        tick(3);
        `CHK("can_tx", 1'h1, can_tx)
        `CHK("retransmit_enable", 1'h1, retransmit_enable)
        rst_n <= 1'h1;
        tick(1);
        // Protected writes need both config change and init
        check_reg(`CTRL_OFFSET, 32'hFF, 32'h01, "ctrl");
        wr(`FD_CTRL_OFFSET, 32'h3);
        check_reg(`FD_CTRL_OFFSET, 32'h3, 32'h0, "fd");
        wr(`CTRL_OFFSET, 32'h41);
        wr(`FD_CTRL_OFFSET, 32'h3);
        check_reg(`FD_CTRL_OFFSET, 32'h3, 32'h3, "fd");
        `CHK("fast_data_operation_enable", 1'h1, fast_data_operation_enable)
        wr(`CTRL_OFFSET, 32'h40);
        wr(`FD_CTRL_OFFSET, 32'h0);
        check_reg(`FD_CTRL_OFFSET, 32'h3, 32'h3, "fd");
        u_bus.levels(1'h0, 1'h1, 1'h0, 1'h1);
        tick(3);
        `CHK("can_tx", 1'h1, can_tx)
        `CHK("tx_allowed", 1'h0, tx_allowed)
        `CHK("counters_frozen", 1'h1, counters_frozen)
        // Restricted mode is left before any loopback is touched
        wr(`CTRL_OFFSET, 32'h41);
        wr(`FD_CTRL_OFFSET, 32'h0);
        wr(`CTRL_OFFSET, 32'h0);
        `CHK("counters_frozen", 1'h0, counters_frozen)
        wr(`CTRL_OFFSET, 32'h01);
        u_bus.levels(1'h1, 1'h1, 1'h0, 1'h0);
        wr(`TEST_OFFSET, 32'h7C);
        check_reg(`TEST_OFFSET, 32'hFF, 32'h80, "test");
        u_bus.levels(1'h1, 1'h0, 1'h0, 1'h0);
        tick(2);
        check_reg(`TEST_OFFSET, 32'hFF, 32'h00, "test");
        wr(`CTRL_OFFSET, 32'h80);
        foreach (rows[i]) begin
            // Pin functions other than serial only with every test mode off
            wr(`TEST_OFFSET, {24'h0, rows[i].tval});
            u_bus.levels(rows[i].ctx, rows[i].oth, rows[i].sp, 1'h0);
            tick(3);
            `CHK("can_tx", rows[i].exp_tx, can_tx)
            `CHK("core_rx", rows[i].exp_rx, core_rx)
            `CHK("ack_error_ignore", rows[i].tval[4], ack_error_ignore)
            `CHK("loopback_store", rows[i].tval[4], loopback_store)
        end
        wr(`TEST_OFFSET, 32'h40);
        wr(`CTRL_OFFSET, 32'h0);
        u_bus.levels(1'h1, 1'h1, 1'h0, 1'h0);
        tick(3);
        `CHK("can_tx", 1'h1, can_tx)
        // Direct buffer: set one transmits, set two captures
        wr(`CTRL_OFFSET, 32'h80);
        wr(`TEST_OFFSET, 32'h04);
        `CHK("filter_bypass", 1'h1, filter_bypass)
        `CHK("ready_out", 1'h0, ready_out)
        wr(`SET_TWO_REQ_OFFSET, 32'h8000);
        u_bus.pulse(4);
        // Let the pulse counter see the last capture before looking
        tick(1);
        `CHK("set_two_capture", 2, n_cap)
        wr(`SET_ONE_REQ_OFFSET, 32'h8000);
        check_reg(`SET_ONE_REQ_OFFSET, 32'h8000, 32'h8000, "busy");
        u_bus.pulse(0);
        u_bus.pulse(1);
        u_bus.pulse(3);
        check_reg(`SET_ONE_REQ_OFFSET, 32'h8000, 32'h8000, "busy");
        u_bus.pulse(0);
        u_bus.pulse(1);
        u_bus.pulse(2);
        `CHK("tx_load", 2, n_load)
        check_reg(`SET_ONE_REQ_OFFSET, 32'h8000, 32'h0, "busy");
        wr(`SET_ONE_REQ_OFFSET, 32'h8000);
        wr(`SET_ONE_REQ_OFFSET, 32'h0);
        u_bus.pulse(0);
        tick(2);
        `CHK("tx_load", 2, n_load)
        // Single-shot: request drops at start, new data only on success
        wr(`CTRL_OFFSET, 32'h20);
        `CHK("retransmit_enable", 1'h0, retransmit_enable)
        wr(`SET_ONE_REQ_OFFSET, 32'h8000);
        check_reg(`STATUS_OFFSET, 32'h3, 32'h3, "status");
        // Abort state is gone now, so only the disable bit holds this low
        `CHK("retransmit_enable", 1'h0, retransmit_enable)
        `CHK("tx_allowed", 1'h1, tx_allowed)
        `CHK("ready_out", 1'h1, ready_out)
        u_bus.pulse(0);
        u_bus.pulse(1);
        check_reg(`STATUS_OFFSET, 32'h3, 32'h2, "status");
        u_bus.pulse(3);
        u_bus.pulse(0);
        check_reg(`STATUS_OFFSET, 32'h3, 32'h2, "status");
        wr(`SET_ONE_REQ_OFFSET, 32'h8000);
        check_reg(`STATUS_OFFSET, 32'h3, 32'h3, "status");
        u_bus.pulse(0);
        u_bus.pulse(1);
        u_bus.pulse(2);
        check_reg(`STATUS_OFFSET, 32'h3, 32'h0, "status");
        stop_test();
    end
endmodule

`default_nettype wire
